/* rtl/adc_scan_pkg.sv */
// Constants shared by the scan sequencer
package adc_scan_pkg;
  // Register indices on the plain register port (word addresses)
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_TRIG = 6'h01;
  localparam logic [5:0] REG_GRPSEL = 6'h02;
  // Kept clear of the three group select words at 2, 3 and 4
  localparam logic [5:0] REG_EXTSEL = 6'h09;
  localparam logic [5:0] REG_SHCTRL = 6'h0a;
  localparam logic [5:0] REG_DISC = 6'h05;
  localparam logic [5:0] REG_STATUS = 6'h06;
  localparam logic [5:0] REG_CMPA = 6'h07;
  localparam logic [5:0] REG_CMPB = 6'h08;
  localparam logic [5:0] REG_ORDER0 = 6'h10;
  localparam logic [5:0] REG_SST0 = 6'h20;
  // Table sizes
  localparam int NUM_ORDER = 14;
  localparam int NUM_CHAN = 14;
  localparam int NUM_SST = 17;
  // CTRL fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_DBL = 3;
  localparam int CTRL_PRIO = 4;
  localparam int CTRL_RESCAN = 5;
  localparam int CTRL_RESTART = 6;
  localparam int CTRL_THREE = 7;
  localparam int CTRL_IRQEN = 8;
  localparam int CTRL_EVCMP = 9;
  // Scan modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_GROUP = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  // Trigger source codes, one 2-bit field per group
  localparam logic [1:0] TRG_NONE = 2'h0;
  localparam logic [1:0] TRG_MTU = 2'h1;
  localparam logic [1:0] TRG_TMR = 2'h2;
  localparam logic [1:0] TRG_ELC = 2'h3;
  // EXTSEL fields
  localparam int EXT_A = 0;
  localparam int EXT_B = 1;
  localparam int EXT_ACC = 2;
  localparam int TS_A = 3;
  localparam int TS_B = 4;
  localparam int TS_ACC = 5;
  localparam int OC_B = 6;
  localparam int EXT_PIN_EN = 7;
  // Sampling limits in conversion clock cycles
  localparam logic [7:0] SST_MIN = 8'h0c;
  localparam logic [7:0] SST_MAX = 8'hfc;
  localparam logic [7:0] SST_RST = 8'h0c;
  // Disconnection assist period encodings
  localparam logic [3:0] DISC_OFF = 4'h0;
  localparam logic [3:0] DISC_3 = 4'h3;
  localparam logic [3:0] DISC_6 = 4'h6;
  localparam logic [3:0] DISC_9 = 4'h9;
  localparam logic [3:0] DISC_12 = 4'hc;
  localparam logic [3:0] DISC_15 = 4'hf;
  // Conversion length of one channel in conversion clock enables
  localparam logic [7:0] CONV_CYC = 8'h0d;
  // Group indices
  localparam int GA = 0;
  localparam int GB = 1;
  localparam int GC = 2;
  // Extended input slots in the order table (codes beyond analog channels)
  localparam logic [4:0] CH_EXT0 = 5'h0e;
  localparam logic [4:0] CH_EXT1 = 5'h0f;
  localparam logic [4:0] CH_TS = 5'h10;
  localparam logic [4:0] CH_OC = 5'h11;
endpackage : adc_scan_pkg

/* rtl/adc_scan_sequencer.sv */
// Group scan sequencer of a successive-approximation converter unit
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module adc_scan_sequencer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic conv_clk_en,
  input wire logic mtu_trig,
  input wire logic tmr_trig,
  input wire logic elc_trig,
  input wire logic ext_conv_trigger_n,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  output logic conv_start,
  output logic [4:0] conv_chan,
  output logic [7:0] conv_sample_time,
  output logic [3:0] charge_period_sel,
  output logic conv_accum,
  output logic scan_end_irq,
  output logic group_b_end_irq,
  output logic group_c_end_irq,
  output logic window_a_compare_irq,
  output logic window_b_compare_irq,
  output logic elc_event
);
  // Sequencer states, Gray coded along idle-prep-sample-wait
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PREP = 2'b01,
    ST_SAMP = 2'b11,
    ST_WAIT = 2'b10
  } seq_state_e;

  localparam int NUM_ORDER_L = adc_scan_pkg::NUM_ORDER;
  localparam int NUM_SST_L = adc_scan_pkg::NUM_SST;

  seq_state_e state_q; // Current state
  logic [9:0] ctrl_q; // Mode and option bits
  logic [5:0] trig_q; // Trigger source per group
  logic [13:0] grp_sel_q [3]; // Channel selection per group
  logic [7:0] ext_q; // Extended input selects
  logic [7:0] sh_sample_time; // Dedicated S/H sampling time
  logic [3:0] disc_q; // Assist period code
  logic [11:0] cmpa_q; // Window A threshold
  logic [11:0] cmpb_q; // Window B threshold
  logic [4:0] order_q [NUM_ORDER_L]; // Conversion order slots
  logic [7:0] sst_q [NUM_SST_L]; // Sampling time per input
  logic [2:0] pend_q; // Pending group triggers
  logic [2:0] resume_q; // Preempted groups to resume
  logic [1:0] grp_q; // Active group
  logic [4:0] slot_q; // Order slot pointer
  logic [4:0] resume_slot_q [3]; // Saved pointer per group
  logic dbl_second_q; // Second scan of double trigger
  logic [7:0] cnt_q; // Conversion clock count
  logic ext_d1_q; // Delayed pin level for edge find
  logic start_pulse; // Software start write
  logic [2:0] trig_hit; // New trigger per group
  logic [1:0] top_grp; // Highest pending group
  logic top_valid; // Any pending
  logic preempt; // Higher group must take over
  logic slot_sel; // Current slot selected in group
  logic scan_done; // Last order slot reached
  logic [4:0] cur_ch; // Channel of current slot

  // Legal assist codes only; illegal writes leave the field unchanged
  function automatic logic disc_ok(input logic [3:0] v);
    disc_ok = (v == adc_scan_pkg::DISC_OFF) || (v == adc_scan_pkg::DISC_3) ||
      (v == adc_scan_pkg::DISC_6) || (v == adc_scan_pkg::DISC_9) ||
      (v == adc_scan_pkg::DISC_12) || (v == adc_scan_pkg::DISC_15);
  endfunction

  // Is a channel code part of a group's scan
  function automatic logic in_group(input logic [1:0] g, input logic [4:0] c,
    input logic [13:0] sel, input logic [7:0] ex);
    logic r;
    r = 1'b0;
    if (c < adc_scan_pkg::CH_EXT0)
      r = sel[c[3:0]];
    else if (c == adc_scan_pkg::CH_EXT0 || c == adc_scan_pkg::CH_EXT1)
      r = (g == 2'(adc_scan_pkg::GA)) ? ex[adc_scan_pkg::EXT_A] :
          (g == 2'(adc_scan_pkg::GB)) ? ex[adc_scan_pkg::EXT_B] : 1'b0;
    // sensor in group A or B, reference in group B only
    else if (c == adc_scan_pkg::CH_TS)
      r = (g == 2'(adc_scan_pkg::GB)) ? ex[adc_scan_pkg::TS_B] :
          (g == 2'(adc_scan_pkg::GA)) ? ex[adc_scan_pkg::TS_A] : 1'b0;
    else if (c == adc_scan_pkg::CH_OC)
      r = (g == 2'(adc_scan_pkg::GB)) & ex[adc_scan_pkg::OC_B];
    in_group = r;
  endfunction

  // Register writes: control, selections, timings
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= '0;
      trig_q <= '0;
      ext_q <= '0;
      disc_q <= adc_scan_pkg::DISC_OFF;
      cmpa_q <= '0;
      cmpb_q <= '0;
      sh_sample_time <= adc_scan_pkg::SST_RST;
      for (int i = 0; i < 3; i++)
        grp_sel_q[i] <= '0;
      for (int i = 0; i < NUM_ORDER_L; i++)
        order_q[i] <= 5'(i);
      for (int i = 0; i < NUM_SST_L; i++)
        sst_q[i] <= adc_scan_pkg::SST_RST;
    end
    else if (reg_wr)
    begin
      // Address decode by if chain
      if (reg_addr == adc_scan_pkg::REG_CTRL)
        ctrl_q <= {reg_wdata[9:1], 1'b0};
      else if (reg_addr == adc_scan_pkg::REG_TRIG)
        trig_q <= reg_wdata[5:0];
      else if (reg_addr == adc_scan_pkg::REG_GRPSEL)
        grp_sel_q[adc_scan_pkg::GA] <= reg_wdata[13:0];
      else if (reg_addr == adc_scan_pkg::REG_GRPSEL + 6'h01)
        grp_sel_q[adc_scan_pkg::GB] <= reg_wdata[13:0];
      else if (reg_addr == adc_scan_pkg::REG_GRPSEL + 6'h02)
        grp_sel_q[adc_scan_pkg::GC] <= reg_wdata[13:0];
      else if (reg_addr == adc_scan_pkg::REG_EXTSEL)
        ext_q <= reg_wdata[7:0];
      else if (reg_addr == adc_scan_pkg::REG_SHCTRL)
      begin
        if (reg_wdata[7:0] < adc_scan_pkg::SST_MIN)
          sh_sample_time <= adc_scan_pkg::SST_MIN;
        else if (reg_wdata[7:0] > adc_scan_pkg::SST_MAX)
          sh_sample_time <= adc_scan_pkg::SST_MAX;
        else
          sh_sample_time <= reg_wdata[7:0];
      end
      else if (reg_addr == adc_scan_pkg::REG_DISC)
      begin
        if (disc_ok(reg_wdata[3:0]))
          disc_q <= reg_wdata[3:0];
      end
      else if (reg_addr == adc_scan_pkg::REG_CMPA)
        cmpa_q <= reg_wdata[11:0];
      else if (reg_addr == adc_scan_pkg::REG_CMPB)
        cmpb_q <= reg_wdata[11:0];
      else if (reg_addr >= adc_scan_pkg::REG_ORDER0 &&
               reg_addr < adc_scan_pkg::REG_ORDER0 + 6'(NUM_ORDER_L))
        order_q[4'(reg_addr - adc_scan_pkg::REG_ORDER0)] <= reg_wdata[4:0];
      else if (reg_addr >= adc_scan_pkg::REG_SST0 &&
               reg_addr < adc_scan_pkg::REG_SST0 + 6'(NUM_SST_L))
        sst_q[5'(reg_addr - adc_scan_pkg::REG_SST0)] <= reg_wdata[7:0];
    end
  end

  // Software start is a write of the start bit
  assign start_pulse = reg_wr && reg_addr == adc_scan_pkg::REG_CTRL &&
    reg_wdata[adc_scan_pkg::CTRL_START];

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      if (reg_addr == adc_scan_pkg::REG_CTRL)
        reg_rdata <= {6'h00, ctrl_q};
      else if (reg_addr == adc_scan_pkg::REG_TRIG)
        reg_rdata <= {10'h000, trig_q};
      else if (reg_addr == adc_scan_pkg::REG_EXTSEL)
        reg_rdata <= {8'h00, ext_q};
      else if (reg_addr == adc_scan_pkg::REG_SHCTRL)
        reg_rdata <= {8'h00, sh_sample_time};
      else if (reg_addr == adc_scan_pkg::REG_DISC)
        reg_rdata <= {12'h000, disc_q};
      else if (reg_addr == adc_scan_pkg::REG_STATUS)
        reg_rdata <= {1'b0, slot_q, resume_q, pend_q, grp_q, state_q};
      else if (reg_addr >= adc_scan_pkg::REG_SST0 &&
               reg_addr < adc_scan_pkg::REG_SST0 + 6'(NUM_SST_L))
        reg_rdata <= {8'h00, sst_q[5'(reg_addr - adc_scan_pkg::REG_SST0)]};
      else
        reg_rdata <= '0;
    end
    else
      reg_rdata <= '0;
  end

  // Pin edge detector; pin is taken as synchronous
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ext_d1_q <= 1'b1;
    else
      ext_d1_q <= ext_conv_trigger_n;
  end

  // Trigger selection per group
  always_comb
  begin
    for (int g = 0; g < 3; g++)
    begin
      case (trig_q[2*g +: 2])
        adc_scan_pkg::TRG_MTU: trig_hit[g] = mtu_trig;
        adc_scan_pkg::TRG_TMR: trig_hit[g] = tmr_trig;
        adc_scan_pkg::TRG_ELC: trig_hit[g] = elc_trig;
        default: trig_hit[g] = 1'b0;
      endcase
    end
    // Software start and pin both start group A
    trig_hit[adc_scan_pkg::GA] = trig_hit[adc_scan_pkg::GA] | start_pulse |
      // falling pin edge starts this unit
      (ext_q[adc_scan_pkg::EXT_PIN_EN] & ext_d1_q & ~ext_conv_trigger_n);
    // group C only in three-group mode
    if (!ctrl_q[adc_scan_pkg::CTRL_THREE] ||
        ctrl_q[2:1] != adc_scan_pkg::MODE_GROUP)
      trig_hit[adc_scan_pkg::GC] = 1'b0;
    if (ctrl_q[2:1] != adc_scan_pkg::MODE_GROUP)
      trig_hit[adc_scan_pkg::GB] = 1'b0;
  end

  always_comb
  begin
    top_valid = |pend_q;
    if (pend_q[adc_scan_pkg::GA])
      top_grp = 2'(adc_scan_pkg::GA);
    else if (pend_q[adc_scan_pkg::GB])
      top_grp = 2'(adc_scan_pkg::GB);
    else
      top_grp = 2'(adc_scan_pkg::GC);
  end

  // Channel of current slot and whether it belongs to the active group
  assign cur_ch = order_q[slot_q[3:0]];
  assign slot_sel = in_group(grp_q, cur_ch, grp_sel_q[grp_q], ext_q);
  assign scan_done = slot_q == 5'(NUM_ORDER_L - 1);
  // higher group pending while lower is busy
  assign preempt = ctrl_q[adc_scan_pkg::CTRL_PRIO] && state_q != ST_IDLE &&
    top_valid && top_grp < grp_q;

  // Scan engine: slot walk, preemption, resume and end pulses
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      pend_q <= '0;
      resume_q <= '0;
      grp_q <= '0;
      slot_q <= '0;
      cnt_q <= '0;
      dbl_second_q <= 1'b0;
      conv_start <= 1'b0;
      scan_end_irq <= 1'b0;
      group_b_end_irq <= 1'b0;
      group_c_end_irq <= 1'b0;
      elc_event <= 1'b0;
      for (int g = 0; g < 3; g++)
        resume_slot_q[g] <= '0;
    end
    else
    begin
      conv_start <= 1'b0;
      scan_end_irq <= 1'b0;
      group_b_end_irq <= 1'b0;
      group_c_end_irq <= 1'b0;
      elc_event <= 1'b0;
      // triggers collect until served; new wins over take
      pend_q <= pend_q | trig_hit;
      case (state_q)
        ST_IDLE:
        begin
          // Pending trigger wins over a resume of the same group
          if (top_valid)
          begin
            grp_q <= top_grp;
            slot_q <= '0;
            pend_q <= (pend_q & ~(3'b001 << top_grp)) | trig_hit;
            state_q <= ST_PREP;
          end
          else if (|resume_q)
          begin
            grp_q <= resume_q[0] ? 2'd0 : (resume_q[1] ? 2'd1 : 2'd2);
            // restart from saved slot or first
            slot_q <= ctrl_q[adc_scan_pkg::CTRL_RESTART] ?
              resume_slot_q[resume_q[0] ? 0 : (resume_q[1] ? 1 : 2)] : 5'h00;
            resume_q <= resume_q & (resume_q - 3'b001);
            state_q <= ST_PREP;
          end
        end
        ST_PREP:
        begin
          if (preempt)
          begin
            // keep preempted group only when rescan set
            if (ctrl_q[adc_scan_pkg::CTRL_RESCAN])
              resume_q[grp_q] <= 1'b1;
            resume_slot_q[grp_q] <= slot_q;
            state_q <= ST_IDLE;
          end
          else if (slot_sel)
          begin
            conv_start <= 1'b1;
            cnt_q <= '0;
            state_q <= ST_SAMP;
          end
          else if (scan_done)
            state_q <= ST_WAIT;
          else
            slot_q <= slot_q + 5'h01;
        end
        ST_SAMP:
        begin
          // Wait for converter result; preemption waits for channel end
          if (conv_clk_en && cnt_q != 8'hff)
            cnt_q <= cnt_q + 8'h01;
          if (conv_done)
          begin
            // window A match drives the event in single mode
            if (ctrl_q[adc_scan_pkg::CTRL_EVCMP] &&
                ctrl_q[2:1] == adc_scan_pkg::MODE_SINGLE &&
                conv_result > cmpa_q)
              elc_event <= 1'b1;
            if (scan_done)
              state_q <= ST_WAIT;
            else
            begin
              slot_q <= slot_q + 5'h01;
              state_q <= ST_PREP;
            end
          end
        end
        ST_WAIT:
        begin
          state_q <= ST_IDLE;
          slot_q <= '0;
          if (ctrl_q[adc_scan_pkg::CTRL_DBL] && grp_q == 2'd0 &&
              !dbl_second_q)
            // first of double scan raises nothing
            dbl_second_q <= 1'b1;
          else
          begin
            dbl_second_q <= 1'b0;
            // group A after a single scan or the second of a double
            if (grp_q == 2'd0)
              scan_end_irq <= ctrl_q[adc_scan_pkg::CTRL_IRQEN];
            else if (grp_q == 2'd1)
              group_b_end_irq <= ctrl_q[adc_scan_pkg::CTRL_IRQEN];
            else
              group_c_end_irq <= ctrl_q[adc_scan_pkg::CTRL_IRQEN];
            // event when nothing else is scheduled
            if (!top_valid && resume_q == 3'b000 &&
                !ctrl_q[adc_scan_pkg::CTRL_EVCMP])
              elc_event <= 1'b1;
          end
          if (ctrl_q[2:1] == adc_scan_pkg::MODE_CONT)
            pend_q[adc_scan_pkg::GA] <= 1'b1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Window compare on each result; pulses per converted channel
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      window_a_compare_irq <= 1'b0;
      window_b_compare_irq <= 1'b0;
    end
    else
    begin
      window_a_compare_irq <= conv_done && conv_result > cmpa_q;
      window_b_compare_irq <= conv_done && conv_result > cmpb_q;
    end
  end

  // Drive converter side; sample time picks dedicated or per-input value
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      conv_chan <= '0;
      conv_sample_time <= adc_scan_pkg::SST_RST;
      conv_accum <= 1'b0;
      charge_period_sel <= adc_scan_pkg::DISC_OFF;
    end
    else
    begin
      conv_chan <= cur_ch;
      charge_period_sel <= disc_q;
      conv_sample_time <= (cur_ch < 5'h03) ? sh_sample_time :
        sst_q[(cur_ch < 5'(NUM_SST_L)) ? cur_ch : 5'h00];
      if (cur_ch == adc_scan_pkg::CH_EXT0 || cur_ch == adc_scan_pkg::CH_EXT1)
        conv_accum <= ext_q[adc_scan_pkg::EXT_ACC];
      else if (cur_ch == adc_scan_pkg::CH_TS)
        conv_accum <= ext_q[adc_scan_pkg::TS_ACC];
      else
        conv_accum <= 1'b0;
    end
  end

  // single scan end handled as group A completion

  // scan end request never lasts two cycles
  chk_irq_one_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    scan_end_irq |=> !scan_end_irq) else $error("scan end held");
  chk_preempt_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_q == ST_PREP && preempt) |=> state_q == ST_IDLE)
    else $error("no preempt");
  chk_disc_legal: assert property (@(posedge clk_sys) disable iff (sys_rst)
    disc_ok(disc_q)) else $error("bad assist code");
  chk_sst_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sh_sample_time >= adc_scan_pkg::SST_MIN &&
    sh_sample_time <= adc_scan_pkg::SST_MAX)
    else $error("sample time out");
  chk_trig_pend: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (trig_hit[1] && !(state_q == ST_IDLE && top_valid)) |=> pend_q[1])
    else $error("trigger lost");
  // no end request on first double scan
  chk_dbl_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_q == ST_WAIT && ctrl_q[3] && grp_q == 2'd0 && !dbl_second_q)
    |=> !scan_end_irq) else $error("early double end");
  // group B end only after B scan
  chk_b_end: assert property (@(posedge clk_sys) disable iff (sys_rst)
    group_b_end_irq |-> $past(state_q) == ST_WAIT && $past(grp_q) == 2'd1)
    else $error("b end stray");
  chk_cmp_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    window_a_compare_irq |-> $past(conv_done))
    else $error("compare stray");
endmodule : adc_scan_sequencer
`default_nettype wire

/* tb/conv_core_model.sv */
// Converter core stand-in: answers each start after a random delay
`timescale 1ns/1ns
`default_nettype none
module conv_core_model (
  input wire logic clk_sys,
  input wire logic conv_start,
  output logic conv_done,
  output logic [11:0] conv_result
);
  int left_q = 0; // Cycles left on the running conversion
  initial
  begin
    conv_done = 1'b0;
    conv_result = 12'h000;
  end
  // Result line flips while idle so stale data never looks valid
  always @(posedge clk_sys)
  begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (conv_start === 1'b1)
      left_q <= 1 + ($urandom % 16);
    else if (left_q == 1)
    begin
      conv_done <= 1'b1;
      conv_result <= 12'($urandom);
    end
    if (left_q > 0 && conv_start !== 1'b1)
      left_q <= left_q - 1;
  end
endmodule // conv_core_model
`default_nettype wire

/* tb/adc_scan_sequencer_tb.sv */
// Self-checking bench for the scan sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_scan_sequencer_tb;
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_val;
  logic conv_clk_en = 1'b0, mtu_trig = 1'b0, tmr_trig = 1'b0;
  logic elc_trig = 1'b0, ext_conv_trigger_n = 1'b1; // Pin idles high
  logic conv_done, conv_start, conv_accum, scan_end_irq, group_b_end_irq;
  logic group_c_end_irq, window_a_compare_irq, window_b_compare_irq;
  logic elc_event;
  logic [11:0] conv_result;
  logic [4:0] conv_chan;
  logic [7:0] conv_sample_time, v;
  logic [3:0] charge_period_sel;
  logic [2:0] pv = 3'h0; // Previous cycle of scan end, group B end and event pulses
  logic [13:0] sel;
  logic [3:0] codes[6] = '{4'h0, 4'h3, 4'h6, 4'h9, 4'hc, 4'hf};
  int failures = 0, tests_run = 0, cycles = 0, n_conv = 0, n_elc = 0;
  int n_win = 0, n_win_exp = 0, n_long = 0, base, w0;
  int n_winb = 0, n_winb_exp = 0;
  int obs_q[$], exp_q[$]; // End requests seen and predicted, in order
  adc_scan_sequencer dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .conv_clk_en, .mtu_trig, .tmr_trig,
    .elc_trig, .ext_conv_trigger_n, .conv_done, .conv_result, .conv_start,
    .conv_chan, .conv_sample_time, .charge_period_sel, .conv_accum,
    .scan_end_irq, .group_b_end_irq, .group_c_end_irq,
    .window_a_compare_irq, .window_b_compare_irq, .elc_event);
  conv_core_model core (.clk_sys, .conv_start, .conv_done, .conv_result);
  initial
    forever #25 clk_sys = ~clk_sys;
  // Monitor: counts pulses, predicts compares, guards the run length
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    conv_clk_en <= ~conv_clk_en;
    pv <= {scan_end_irq, group_b_end_irq, elc_event};
    if (|({scan_end_irq, group_b_end_irq, elc_event} & pv))
      n_long <= n_long + 1;
    if (conv_start === 1'b1)
      n_conv <= n_conv + 1;
    if (elc_event === 1'b1)
      n_elc <= n_elc + 1;
    if (window_a_compare_irq === 1'b1)
      n_win <= n_win + 1;
    if (conv_done === 1'b1 && conv_result > 12'h800)
      n_win_exp <= n_win_exp + 1;
    if (window_b_compare_irq === 1'b1)
      n_winb <= n_winb + 1;
    if (conv_done === 1'b1 && conv_result > 12'h400)
      n_winb_exp <= n_winb_exp + 1;
    if (scan_end_irq === 1'b1)
      obs_q.push_back(1);
    if (group_b_end_irq === 1'b1)
      obs_q.push_back(2);
    if (group_c_end_irq === 1'b1)
      obs_q.push_back(3);
    if (cycles == 60000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic trig(input logic [2:0] m);
    @(posedge clk_sys);
    {elc_trig, tmr_trig, mtu_trig} <= m;
    @(posedge clk_sys);
    {elc_trig, tmr_trig, mtu_trig} <= 3'h0;
  endtask
  function automatic logic [15:0] ctrl(input logic [1:0] m,
    input logic [4:0] f, input logic s);
    return {7'h00, 1'b1, f, m, s};
  endfunction
  task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_cnt(input int got, input int exp);
    check_reg(16'(got), 16'(exp));
  endtask
  // Bounded wait for n end requests, then a quiet spell for strays
  task automatic check_evt(input int n);
    for (int i = 0; i < 4000 && obs_q.size() < n; i++)
      @(posedge clk_sys);
    repeat (200) @(posedge clk_sys);
    check_cnt(obs_q.size(), exp_q.size());
    foreach (exp_q[i])
      check_cnt((i < obs_q.size()) ? obs_q[i] : 0, exp_q[i]);
    obs_q.delete();
    exp_q.delete();
  endtask
  task automatic complete_run();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(45536));
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 check_reg(16'(conv_sample_time), 16'h000c);
    rd(adc_scan_pkg::REG_SST0);
    check_reg(rd_val, 16'h000c);
    rd(6'h3f);
    check_reg(rd_val, 16'h0000);
    // Sampling field clamps at both ends and passes legal values
    for (int k = 0; k < 3; k++)
    begin
      v = (k == 0) ? 8'h05 : (k == 1) ? 8'hff : 8'(12 + $urandom % 241);
      wr(adc_scan_pkg::REG_SHCTRL, {8'h00, v});
      rd(adc_scan_pkg::REG_SHCTRL);
      check_reg(rd_val, {8'h00, k == 0 ? 8'h0c : k == 1 ? 8'hfc : v});
    end
    // Each legal assist code sticks; an illegal one is dropped
    foreach (codes[i])
    begin
      wr(adc_scan_pkg::REG_DISC, 16'(codes[i]));
      wr(adc_scan_pkg::REG_DISC, 16'h0005);
      rd(adc_scan_pkg::REG_DISC);
      check_reg(rd_val, 16'(codes[i]));
      check_reg(16'(charge_period_sel), 16'(codes[i]));
    end
    sel = 14'($urandom) | 14'h0001;
    wr(adc_scan_pkg::REG_GRPSEL, {2'h0, sel});
    wr(adc_scan_pkg::REG_CMPA, 16'h0800);
    wr(adc_scan_pkg::REG_CMPB, 16'h0400);
    wr(adc_scan_pkg::REG_CTRL, ctrl(adc_scan_pkg::MODE_SINGLE, 5'h00, 1'b1));
    exp_q.push_back(1);
    check_evt(1);
    check_cnt(n_conv, $countones(sel));
    check_cnt(n_elc, 1);
    // Double trigger: no request after the first of two scans
    base = n_conv;
    wr(adc_scan_pkg::REG_CTRL, ctrl(adc_scan_pkg::MODE_SINGLE, 5'h01, 1'b1));
    check_evt(0);
    wr(adc_scan_pkg::REG_CTRL, ctrl(adc_scan_pkg::MODE_SINGLE, 5'h01, 1'b1));
    exp_q.push_back(1);
    check_evt(1);
    check_cnt(n_conv - base, 2 * $countones(sel));
    // Three groups: B preempts C, C resumes only when rescan is on
    wr(adc_scan_pkg::REG_GRPSEL + 6'h1, 16'h0006);
    wr(adc_scan_pkg::REG_GRPSEL + 6'h2, 16'h3fff);
    wr(adc_scan_pkg::REG_TRIG, 16'h0036);
    for (int r = 1; r >= 0; r--)
    begin
      wr(adc_scan_pkg::REG_CTRL,
        ctrl(adc_scan_pkg::MODE_GROUP, {1'b1, 1'(r), 1'(r), 2'b10}, 1'b0));
      base = n_conv;
      trig(3'b100);
      for (int i = 0; i < 400 && n_conv == base; i++)
        @(posedge clk_sys);
      trig(3'b001);
      exp_q.push_back(2);
      if (r == 1)
        exp_q.push_back(3);
      check_evt(1 + r);
      // Resume from the unconverted slot: B's two plus all of C once
      if (r == 1)
        check_cnt(n_conv - base, 16);
    end
    trig(3'b010);
    exp_q.push_back(1);
    check_evt(1);
    // Falling edge on the enabled trigger pin starts group A
    wr(adc_scan_pkg::REG_EXTSEL, 16'h0080);
    @(posedge clk_sys);
    ext_conv_trigger_n <= 1'b0;
    @(posedge clk_sys);
    ext_conv_trigger_n <= 1'b1;
    exp_q.push_back(1);
    check_evt(1);
    // Compare-driven event replaces the scan-end event in single mode
    base = n_elc;
    w0 = n_win_exp;
    wr(adc_scan_pkg::REG_CTRL,
      ctrl(adc_scan_pkg::MODE_SINGLE, 5'h00, 1'b1) | 16'h0200);
    exp_q.push_back(1);
    check_evt(1);
    check_cnt(n_elc - base, n_win_exp - w0);
    // Continuous mode repeats until software returns to single mode
    wr(adc_scan_pkg::REG_CTRL, ctrl(adc_scan_pkg::MODE_CONT, 5'h00, 1'b1));
    for (int i = 0; i < 4000 && obs_q.size() < 3; i++)
      @(posedge clk_sys);
    wr(adc_scan_pkg::REG_CTRL, ctrl(adc_scan_pkg::MODE_SINGLE, 5'h00, 1'b0));
    repeat (600) @(posedge clk_sys);
    base = obs_q.size();
    repeat (600) @(posedge clk_sys);
    check_cnt(obs_q.size(), base);
    check_cnt(int'(base >= 4), 1);
    obs_q.delete();
    check_cnt(n_winb, n_winb_exp);
    check_cnt(n_win, n_win_exp);
    check_cnt(n_long, 0);
    complete_run();
  end
endmodule // adc_scan_sequencer_tb
`default_nettype wire
